// ===== hw/midi_cmd_cfg.svh
// constants for the midi command interface: offsets, codes, timing
// Summary of operation
// - decode command bytes at once; act only on ff and 3f.
// - reset command leaves pass-through, stops serial engine, flushes both fifos.
// - reset outside pass-through loads acknowledge fe after resetting.
// - reset inside pass-through resets fully but gives no acknowledge.
// - in reset state, drop serial input bytes and host data writes.
// - reset state follows the reset command and power-on reset.
// - pass-through command flushes both fifos, acknowledges fe, enables serial.
// - pass-through moves host writes to tx and rx bytes to reads.
// - pass-through command while in pass-through does nothing.
// - acknowledge is the next byte read, after any flush.
// - frames are 31.25 kbaud, start, eight data, no parity, stop.
// - data bytes travel least significant bit first.
// - bit period is 32 microseconds for transmit and receive.
// - full duplex with separate 16-byte tx and rx fifos.
// - activate clear disables decoder, holds interrupt low, low power.
// - activate set enables decoder, interrupt and full power.
// - base address high byte at index 60, low byte at 61.
// - data at base, status read and command write at base plus one.
// - status bit 6 busy, bit 7 low while read data waits.
// - interrupt high while read data waits, low once all is read.
`ifndef MIDI_CMD_CFG_SVH
`define MIDI_CMD_CFG_SVH

`define CMD_RESET      8'hff
`define CMD_PASS       8'h3f
`define ACK_BYTE       8'hfe
`define IDLE_READ      8'h00
`define IDX_ACTIVATE   8'h30
`define IDX_BASE_HI    8'h60
`define IDX_BASE_LO    8'h61
`define BASE_HI_RST    8'h01
`define BASE_LO_RST    8'h00
`define STAT_EMPTY_BIT 7
`define STAT_BUSY_BIT  6
`define FIFO_DEPTH     16
`define CLK_PERIOD_NS  4
`define BIT_TIME_NS    32000
`define BIT_CYCLES     (`BIT_TIME_NS / `CLK_PERIOD_NS)
`define FRAME_LAST     4'd9
`define DATA_BITS      4'd8

`endif

// ===== hw/midi_cmd_pkg.sv
// types shared by the midi command interface
package midi_cmd_pkg;
	typedef enum logic [1:0] {
		MODE_IDLE = 2'b01,
		MODE_PASS = 2'b10
	} mode_t;
	typedef enum logic [1:0] {
		TX_IDLE  = 2'b01,
		TX_SHIFT = 2'b10
	} tx_state_t;
	typedef enum logic [2:0] {
		RX_IDLE  = 3'b001,
		RX_START = 3'b010,
		RX_DATA  = 3'b100
	} rx_state_t;
endpackage

// ===== hw/midi_command_interface.sv
// midi command interface: host port, command decoder, serial engine
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`include "midi_cmd_cfg.svh"
module midi_command_interface #(
	parameter int DEPTH      = `FIFO_DEPTH,
	parameter int BIT_CYCLES = `BIT_CYCLES
) (
	input  wire logic        clk_sys_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] io_addr_i,
	input  wire logic [7:0]  io_wdata_i,
	input  wire logic        io_wr_i,
	input  wire logic        io_rd_i,
	output logic      [7:0]  io_rdata_o,
	input  wire logic [7:0]  cfg_addr_i,
	input  wire logic [7:0]  cfg_wdata_i,
	input  wire logic        cfg_wr_i,
	input  wire logic        cfg_rd_i,
	output logic      [7:0]  cfg_rdata_o,
	input  wire logic        serial_music_in_i,
	output logic             serial_music_out_o,
	output logic             irq_o,
	output logic             power_on_o,
	output midi_cmd_pkg::mode_t mode_o
);
	import midi_cmd_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(BIT_CYCLES + 1);
	localparam logic [CW-1:0] BIT_LAST = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] HALF_LAST = CW'(BIT_CYCLES / 2 - 1);
	localparam logic [PW:0] DEPTH_W = (PW+1)'(DEPTH);

	typedef struct packed {
		mode_t                   mode;
		logic                    ack;
		logic [DEPTH-1:0][7:0]   rxm;
		logic [PW:0]             rxw;
		logic [PW:0]             rxr;
		logic [DEPTH-1:0][7:0]   txm;
		logic [PW:0]             txw;
		logic [PW:0]             txr;
		tx_state_t               txs;
		logic [CW-1:0]           txc;
		logic [3:0]              txn;
		logic [9:0]              txsh;
		logic                    txo;
		logic                    rxi;
		rx_state_t               rxs;
		logic [CW-1:0]           rxc;
		logic [3:0]              rxn;
		logic [7:0]              rxsh;
		logic [7:0]              rd;
		logic [7:0]              crd;
		logic                    act;
		logic [7:0]              bhi;
		logic [7:0]              blo;
	} state_t;

	localparam state_t ST_RST = '{
		mode: MODE_IDLE,
		txs:  TX_IDLE,
		rxs:  RX_IDLE,
		txo:  1'b1,
		rxi:  1'b1,
		bhi:  `BASE_HI_RST,
		blo:  `BASE_LO_RST,
		default: '0
	};

	state_t q_r;
	state_t q_nxt;

	logic              hit;
	logic              data_rd;
	logic              data_wr;
	logic              stat_rd;
	logic              cmd_wr;
	logic              in_pass;
	logic              rx_empty;
	logic              rx_full;
	logic              tx_empty;
	logic              tx_full;
	logic              avail;
	logic [PW:0]       rx_cnt;
	logic [PW:0]       tx_cnt;

	// every check below runs on the system clock and sleeps in reset
	default clocking chk_cb @(posedge clk_sys_i);
	endclocking
	default disable iff (rst_i);

	// occupancy and decode from registered state only
	assign in_pass  = (q_r.mode == MODE_PASS);
	assign rx_cnt   = q_r.rxw - q_r.rxr;
	assign tx_cnt   = q_r.txw - q_r.txr;
	assign rx_empty = (rx_cnt == '0);
	assign rx_full  = (rx_cnt == DEPTH_W);
	assign tx_empty = (tx_cnt == '0);
	assign tx_full  = (tx_cnt == DEPTH_W);
	assign avail    = q_r.ack | ~rx_empty;
	// decoder is dead while deactivated; base low bit is ignored
	assign hit      = q_r.act &&
		(io_addr_i[15:1] == {q_r.bhi, q_r.blo[7:1]});
	assign data_rd  = hit && io_rd_i && !io_addr_i[0];
	assign data_wr  = hit && io_wr_i && !io_addr_i[0];
	assign stat_rd  = hit && io_rd_i && io_addr_i[0];
	assign cmd_wr   = hit && io_wr_i && io_addr_i[0];

	// next-state logic: host port, serial engines, then commands
	always_comb begin
		q_nxt     = q_r;
		q_nxt.rd  = `IDLE_READ;
		q_nxt.crd = 8'h00;
		q_nxt.rxi = serial_music_in_i;

		// data read: a waiting acknowledge goes before fifo data
		if (data_rd) begin
			if (q_r.ack) begin
				q_nxt.rd  = `ACK_BYTE;
				q_nxt.ack = 1'b0;
			end else if (!rx_empty) begin
				q_nxt.rd  = q_r.rxm[q_r.rxr[PW-1:0]];
				q_nxt.rxr = q_r.rxr + 1'b1;
			end
		end
		if (stat_rd) begin
			q_nxt.rd[`STAT_EMPTY_BIT] = ~avail;
			q_nxt.rd[`STAT_BUSY_BIT]  = tx_full;
		end
		// host bytes reach the tx fifo only in pass-through
		if (data_wr && in_pass && !tx_full) begin
			q_nxt.txm[q_r.txw[PW-1:0]] = io_wdata_i;
			q_nxt.txw = q_r.txw + 1'b1;
		end

		// transmitter: one frame of ten bits, lsb first
		case (q_r.txs)
			TX_IDLE: begin
				q_nxt.txo = 1'b1;
				if (!tx_empty && in_pass) begin
					q_nxt.txsh = {1'b1, q_r.txm[q_r.txr[PW-1:0]],
						1'b0};
					q_nxt.txr = q_r.txr + 1'b1;
					q_nxt.txo = 1'b0;
					q_nxt.txc = '0;
					q_nxt.txn = 4'd0;
					q_nxt.txs = TX_SHIFT;
				end
			end
			TX_SHIFT: begin
				q_nxt.txc = q_r.txc + 1'b1;
				if (q_r.txc == BIT_LAST) begin
					q_nxt.txc = '0;
					if (q_r.txn == `FRAME_LAST) begin
						q_nxt.txs = TX_IDLE;
						q_nxt.txo = 1'b1;
					end else begin
						q_nxt.txn  = q_r.txn + 4'd1;
						q_nxt.txsh = {1'b1, q_r.txsh[9:1]};
						q_nxt.txo  = q_r.txsh[1];
					end
				end
			end
			default: begin
				q_nxt.txs = TX_IDLE;
			end
		endcase

		// receiver: verify start at mid-bit, then sample each middle
		case (q_r.rxs)
			RX_IDLE: begin
				q_nxt.rxc = '0;
				if (!q_r.rxi) begin
					q_nxt.rxs = RX_START;
				end
			end
			RX_START: begin
				q_nxt.rxc = q_r.rxc + 1'b1;
				if (q_r.rxc == HALF_LAST) begin
					q_nxt.rxc = '0;
					q_nxt.rxn = 4'd0;
					// a glitch shorter than half a bit is not a frame
					q_nxt.rxs = q_r.rxi ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				q_nxt.rxc = q_r.rxc + 1'b1;
				if (q_r.rxc == BIT_LAST) begin
					q_nxt.rxc = '0;
					if (q_r.rxn != `DATA_BITS) begin
						q_nxt.rxsh = {q_r.rxi, q_r.rxsh[7:1]};
						q_nxt.rxn  = q_r.rxn + 4'd1;
					end else begin
						q_nxt.rxs = RX_IDLE;
						// bad stop bit, full fifo or idle mode drops it
						if (q_r.rxi && in_pass && !rx_full) begin
							q_nxt.rxm[q_r.rxw[PW-1:0]] = q_r.rxsh;
							q_nxt.rxw = q_r.rxw + 1'b1;
						end
					end
				end
			end
			default: begin
				q_nxt.rxs = RX_IDLE;
			end
		endcase

		// commands after both engines, so their flush beats any push this cycle
		if (cmd_wr) begin
			case (io_wdata_i)
				`CMD_RESET: begin
					q_nxt.mode = MODE_IDLE;
					q_nxt.ack  = ~in_pass;
					q_nxt.rxr  = q_nxt.rxw;
					q_nxt.txr  = q_nxt.txw;
					q_nxt.txs  = TX_IDLE;
					q_nxt.txo  = 1'b1;
					q_nxt.rxs  = RX_IDLE;
				end
				`CMD_PASS: begin
					if (!in_pass) begin
						q_nxt.mode = MODE_PASS;
						q_nxt.ack  = 1'b1;
						q_nxt.rxr  = q_nxt.rxw;
						q_nxt.txr  = q_nxt.txw;
						q_nxt.rxs  = RX_IDLE;
					end
				end
				default: begin
				end
			endcase
		end

		// configuration port: activate and base address bytes
		if (cfg_wr_i) begin
			case (cfg_addr_i)
				`IDX_ACTIVATE: q_nxt.act = cfg_wdata_i[0];
				`IDX_BASE_HI: q_nxt.bhi = cfg_wdata_i;
				`IDX_BASE_LO: q_nxt.blo = cfg_wdata_i;
				default: begin
				end
			endcase
		end
		if (cfg_rd_i) begin
			case (cfg_addr_i)
				`IDX_ACTIVATE: q_nxt.crd = {7'h00, q_r.act};
				`IDX_BASE_HI: q_nxt.crd = q_r.bhi;
				`IDX_BASE_LO: q_nxt.crd = q_r.blo;
				default: q_nxt.crd = 8'h00;
			endcase
		end
	end

	// single state register; reset gives idle mode and empty buffers
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			q_r <= ST_RST;
		end else begin
			q_r <= q_nxt;
		end
	end

	// interrupt gated by activate; power follows activate
	assign irq_o              = q_r.act & avail;
	assign power_on_o         = q_r.act;
	assign io_rdata_o         = q_r.rd;
	assign cfg_rdata_o        = q_r.crd;
	assign serial_music_out_o = q_r.txo;
	assign mode_o             = q_r.mode;

	// command decoder checks
	a_reset_flush: assert property (
		cmd_wr && io_wdata_i == `CMD_RESET |=>
		mode_o == MODE_IDLE && rx_empty && tx_empty)
		else $error("reset command did not flush");
	a_reset_ack: assert property (
		cmd_wr && io_wdata_i == `CMD_RESET && !in_pass |=> q_r.ack)
		else $error("reset acknowledge missing");
	a_reset_noack: assert property (
		cmd_wr && io_wdata_i == `CMD_RESET && in_pass |=> !q_r.ack)
		else $error("reset in pass-through acknowledged");
	a_pass_enter: assert property (
		cmd_wr && io_wdata_i == `CMD_PASS && !in_pass |=>
		in_pass && q_r.ack && tx_empty && rx_empty)
		else $error("pass-through entry wrong");
	// the tx pointer may move on a pop, so the rx read pointer shows a flush
	a_pass_noop: assert property (
		cmd_wr && io_wdata_i == `CMD_PASS && in_pass && !q_r.ack |=>
		!q_r.ack && q_r.rxr == $past(q_r.rxr))
		else $error("repeated pass-through not ignored");
	a_cmd_other: assert property (
		cmd_wr && io_wdata_i != `CMD_RESET && io_wdata_i != `CMD_PASS
		|=> $stable(q_r.mode) && $stable(q_r.ack) && $stable(q_r.rxr))
		else $error("unknown command changed state");

	// data port read path
	a_ack_first: assert property (
		data_rd && q_r.ack |=> io_rdata_o == `ACK_BYTE)
		else $error("acknowledge not returned first");
	a_ack_clear: assert property (
		data_rd && q_r.ack |=> !q_r.ack)
		else $error("acknowledge read twice");
	a_rx_pop: assert property (
		data_rd && !q_r.ack && !rx_empty |=>
		q_r.rxr == $past(q_r.rxr) + 1'b1)
		else $error("rx byte not popped");
	// a config write in the same cycle may deactivate, hence its guard
	a_irq_more: assert property (
		data_rd && !q_r.ack && rx_cnt > 1 && !cfg_wr_i |=> irq_o)
		else $error("interrupt lost with data left");
	a_status_empty: assert property (
		stat_rd |=> io_rdata_o[`STAT_EMPTY_BIT] == !$past(avail))
		else $error("status empty bit wrong");
	a_stat_busy: assert property (
		stat_rd |=> io_rdata_o[`STAT_BUSY_BIT] == $past(tx_full) &&
		io_rdata_o[5:0] == 6'h00)
		else $error("status busy or reserved bits wrong");

	// activate gating and configuration
	a_irq_gate: assert property (
		!power_on_o |-> !irq_o)
		else $error("interrupt while deactivated");
	a_dead_read: assert property (
		!power_on_o && io_rd_i |=> io_rdata_o == `IDLE_READ)
		else $error("read answered while deactivated");
	a_cfg_store: assert property (
		cfg_wr_i && cfg_addr_i == `IDX_BASE_HI |=>
		q_r.bhi == $past(cfg_wdata_i))
		else $error("base high byte not stored");

	// host writes and fifo limits
	a_idle_drop: assert property (
		data_wr && !in_pass |=> $stable(q_r.txw))
		else $error("host byte taken in reset state");
	a_txfull_drop: assert property (
		data_wr && tx_full |=> $stable(q_r.txw))
		else $error("byte pushed into full tx fifo");
	a_fifo_bound: assert property (
		rx_cnt <= DEPTH_W && tx_cnt <= DEPTH_W)
		else $error("fifo count past depth");
	a_mode_onehot: assert property (
		mode_o == MODE_IDLE || mode_o == MODE_PASS)
		else $error("mode not one-hot");

	// serial engine
	a_bit_timer: assert property (
		q_r.txs == TX_SHIFT && q_r.txc == BIT_LAST &&
		q_r.txn != `FRAME_LAST |=> q_r.txc == '0 && $changed(q_r.txn))
		else $error("bit period wrong");
	a_bit_bound: assert property (
		q_r.txc <= BIT_LAST && q_r.rxc <= BIT_LAST)
		else $error("bit counter past its period");
	a_tx_start: assert property (
		q_r.txs == TX_SHIFT && q_r.txn == 4'd0 |-> !serial_music_out_o)
		else $error("start bit not low");
	a_tx_stop: assert property (
		q_r.txs == TX_SHIFT && q_r.txn == `FRAME_LAST |-> serial_music_out_o)
		else $error("stop bit not high");
	a_tx_held: assert property (
		!in_pass && q_r.txs == TX_IDLE |=> q_r.txs == TX_IDLE)
		else $error("transmitter started in reset state");
	a_rx_idle_drop: assert property (
		q_r.rxs == RX_DATA && q_r.rxn == `DATA_BITS &&
		q_r.rxc == BIT_LAST && !in_pass |=> $stable(q_r.rxw))
		else $error("serial byte taken in reset state");
	a_rxfull_drop: assert property (
		q_r.rxs == RX_DATA && q_r.rxn == `DATA_BITS &&
		q_r.rxc == BIT_LAST && rx_full |=> $stable(q_r.rxw))
		else $error("byte pushed into full rx fifo");
	a_rx_glitch: assert property (
		q_r.rxs == RX_START && q_r.rxc == HALF_LAST && q_r.rxi |=>
		q_r.rxs == RX_IDLE)
		else $error("short low pulse taken as a frame");
endmodule

// ===== tb/midi_peer.sv
// serial instrument model: sends frames and collects frames it receives
`timescale 1ns/1ps
module midi_peer #(
	parameter int BIT_CYCLES = 16
) (
	input  wire logic clk_i,
	input  wire logic line_i,
	output logic      line_o
);
	logic [7:0] rx_q[$];
	logic [7:0] shift_r;
	int         i;

	initial begin
		line_o = 1'b1;
	end

	// start bit, eight data bits lsb first, stop bit; line idles high after
	task automatic send(input logic [7:0] b);
		logic [9:0] frame;
		frame = {1'b1, b, 1'b0};
		for (int k = 0; k < 10; k++) begin
			line_o <= frame[k];
			repeat (BIT_CYCLES) @(posedge clk_i);
		end
	endtask

	// sample at mid bit so a wrong bit period corrupts the byte seen
	always begin
		@(negedge line_i);
		repeat (BIT_CYCLES / 2) @(posedge clk_i);
		if (line_i === 1'b0) begin
			for (i = 0; i < 8; i++) begin
				repeat (BIT_CYCLES) @(posedge clk_i);
				shift_r[i] = line_i;
			end
			repeat (BIT_CYCLES) @(posedge clk_i);
			if (line_i === 1'b1) begin
				rx_q.push_back(shift_r);
			end
		end
	end
endmodule

// ===== tb/tb.sv
// self-checking bench for the midi command interface
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	fail_count++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb;
	import midi_cmd_pkg::*;
	localparam int BC = 16;
	localparam logic [15:0] DAT = 16'h0330;
	localparam logic [15:0] STA = 16'h0331;
	logic        clk_sys_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [15:0] io_addr_i = 16'h0000;
	logic [7:0]  io_wdata_i = 8'h00;
	logic        io_wr_i = 1'b0;
	logic        io_rd_i = 1'b0;
	logic [7:0]  io_rdata_o;
	logic [7:0]  cfg_addr_i = 8'h00;
	logic [7:0]  cfg_wdata_i = 8'h00;
	logic        cfg_wr_i = 1'b0;
	logic        cfg_rd_i = 1'b0;
	logic [7:0]  cfg_rdata_o;
	logic        peer_line;
	logic        serial_music_out_o;
	logic        irq_o;
	logic        power_on_o;
	mode_t       mode_o;
	int          fail_count = 0;
	int          num_checks = 0;
	int          cycles = 0;

	always #2 clk_sys_i = ~clk_sys_i;

	midi_command_interface #(.BIT_CYCLES(BC)) dut (
		.clk_sys_i(clk_sys_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
		.io_wdata_i(io_wdata_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i),
		.io_rdata_o(io_rdata_o), .cfg_addr_i(cfg_addr_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
		.cfg_rdata_o(cfg_rdata_o), .serial_music_in_i(peer_line),
		.serial_music_out_o(serial_music_out_o), .irq_o(irq_o),
		.power_on_o(power_on_o), .mode_o(mode_o));
	midi_peer #(.BIT_CYCLES(BC)) p (
		.clk_i(clk_sys_i), .line_i(serial_music_out_o), .line_o(peer_line));

	task automatic results();
		if (fail_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// a hang is cut short well past the longest expected run
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			results();
		end
	end

	task automatic io_w(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		io_addr_i <= a;
		io_wdata_i <= d;
		io_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		io_wr_i <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the read edge
	task automatic io_r(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		io_addr_i <= a;
		io_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		io_rd_i <= 1'b0;
		#1 `CHK("io_rdata", e, io_rdata_o)
	endtask

	task automatic cfg_w(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		cfg_addr_i <= a;
		cfg_wdata_i <= d;
		cfg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		cfg_wr_i <= 1'b0;
		#1;
	endtask

	task automatic cfg_r(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		cfg_addr_i <= a;
		cfg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		cfg_rd_i <= 1'b0;
		#1 `CHK("cfg_rdata", e, cfg_rdata_o)
	endtask

	// bounded waits on the peer queue and on the interrupt line
	task automatic wait_q(input int n);
		for (int k = 0; k < 4000 && p.rx_q.size() < n; k++)
			@(posedge clk_sys_i);
		`CHK("peer_count", n, p.rx_q.size())
	endtask

	task automatic wait_irq();
		for (int k = 0; k < 400 && irq_o !== 1'b1; k++)
			@(posedge clk_sys_i);
		#1 `CHK("irq_up", 1'b1, irq_o)
	endtask

	initial begin
		repeat (3) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1 `CHK("mode_rst", MODE_IDLE, mode_o)
		cfg_r(8'h60, 8'h01);
		cfg_r(8'h61, 8'h00);
		cfg_r(8'h10, 8'h00);
		io_r(16'h0101, 8'h00);
		cfg_w(8'h30, 8'h01);
		`CHK("power_on", 1'b1, power_on_o)
		cfg_r(8'h30, 8'h01);
		cfg_w(8'h60, 8'h03);
		cfg_w(8'h61, 8'h30);
		cfg_r(8'h61, 8'h30);
		io_r(STA, 8'h80);
		// reset state drops host data and serial input
		io_w(DAT, 8'h55);
		p.send(8'h11);
		`CHK("tx_idle", 1'b1, serial_music_out_o)
		io_w(STA, 8'h12);
		io_r(STA, 8'h80);
		io_w(STA, 8'hff);
		repeat (2) @(posedge clk_sys_i);
		#1 `CHK("irq_ack", 1'b1, irq_o)
		io_r(STA, 8'h00);
		io_r(DAT, 8'hfe);
		`CHK("irq_read", 1'b0, irq_o)
		io_r(DAT, 8'h00);
		io_w(STA, 8'h3f);
		`CHK("mode_pass", MODE_PASS, mode_o)
		io_r(DAT, 8'hfe);
		// a repeated entry must neither flush a waiting byte nor acknowledge
		p.send(8'h5a);
		wait_irq();
		io_w(STA, 8'h3f);
		io_r(STA, 8'h00);
		io_r(DAT, 8'h5a);
		io_r(STA, 8'h80);
		// both directions at once, two received bytes queued
		fork
			io_w(DAT, 8'h96);
			begin
				p.send(8'h69);
				p.send(8'h3c);
			end
		join
		wait_q(1);
		`CHK("tx_byte", 8'h96, p.rx_q[0])
		io_r(DAT, 8'h69);
		`CHK("irq_more", 1'b1, irq_o)
		io_r(DAT, 8'h3c);
		`CHK("irq_done", 1'b0, irq_o)
		// tx fifo filled until busy shows, one byte too many, then drained
		for (int k = 0; k < 18; k++)
			io_w(DAT, 8'(k));
		io_r(STA, 8'hc0);
		wait_q(18);
		`CHK("tx_last", 8'h10, p.rx_q[17])
		io_r(STA, 8'h80);
		// reset in pass mode: rx flushed and no acknowledge
		p.send(8'h77);
		wait_irq();
		io_w(STA, 8'hff);
		`CHK("mode_back", MODE_IDLE, mode_o)
		io_r(STA, 8'h80);
		`CHK("irq_flush", 1'b0, irq_o)
		// deactivation hides the pending byte from irq and decoder
		io_w(STA, 8'h3f);
		io_r(DAT, 8'hfe);
		p.send(8'h42);
		wait_irq();
		cfg_w(8'h30, 8'h00);
		`CHK("irq_off", 1'b0, irq_o)
		`CHK("power_off", 1'b0, power_on_o)
		io_r(DAT, 8'h00);
		cfg_w(8'h30, 8'h01);
		repeat (2) @(posedge clk_sys_i);
		#1 `CHK("irq_back", 1'b1, irq_o)
		io_r(DAT, 8'h42);
		// rx fifo holds sixteen bytes and drops the seventeenth
		for (int k = 0; k < 17; k++)
			p.send(8'(k + 8'h20));
		for (int k = 0; k < 16; k++)
			io_r(DAT, 8'(k + 8'h20));
		io_r(STA, 8'h80);
		// a reset in mid-run brings back idle mode, empty buffers, defaults
		p.send(8'h24);
		wait_irq();
		@(posedge clk_sys_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1 `CHK("mode_rst2", MODE_IDLE, mode_o)
		`CHK("irq_rst2", 1'b0, irq_o)
		`CHK("power_rst2", 1'b0, power_on_o)
		cfg_r(8'h60, 8'h01);
		cfg_w(8'h30, 8'h01);
		io_r(16'h0101, 8'h80);
		io_r(16'h0100, 8'h00);
		`CHK("peer_total", 18, p.rx_q.size())
		results();
	end
endmodule
